// ---- hw/tpct_top.sv ----
// Three channel pulse capture timer with APB register access
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "tpct_map.svh"
module tpct_top #(
  parameter int CNT_W = 16
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`TPCT_APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic capture_in_0_in,
  input wire logic capture_in_1_in,
  input wire logic capture_in_2_in,
  output logic capture_irq_0_out,
  output logic capture_irq_1_out,
  output logic capture_irq_2_out,
  output logic prescaler_out_out,
  output logic prescaler_oe_out
);
  localparam int NCH = 3;

  // Register state
  logic [7:0] mode_control_reg_q;
  logic [7:0] clock_edge_reg_q;
  logic [7:0] capture_divider_reg_q;
  logic [CNT_W-1:0] free_running_counter_q;
  logic [CNT_W-1:0] cap_q [NCH];
  logic [NCH-1:0] irq_q;
  logic [2:0] div_cnt_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic presc_out_q;
  logic presc_oe_q;

  // Control fields
  wire run_bit = mode_control_reg_q[`TPCT_MODE_RUN_BIT];
  wire prescaler_out_enable = mode_control_reg_q[`TPCT_MODE_POE_BIT];
  wire [1:0] clk_sel = clock_edge_reg_q[`TPCT_CLK_SEL_LSB +: 2];
  wire [1:0] edge_sel [NCH];
  assign edge_sel[0] = clock_edge_reg_q[`TPCT_EDGE0_LSB +: 2];
  assign edge_sel[1] = clock_edge_reg_q[`TPCT_EDGE1_LSB +: 2];
  assign edge_sel[2] = clock_edge_reg_q[`TPCT_EDGE2_LSB +: 2];
  wire [1:0] div_sel = capture_divider_reg_q[1:0];

  // Prescaler and count tick
  logic tick;
  logic presc_sig;
  tpct_prescaler u_presc (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .clk_sel_in(clk_sel),
    .tick_out(tick),
    .presc_sig_out(presc_sig)
  );

  // Address decode
  wire setup = psel_in && !penable_in;
  wire hit_mode = paddr_in == {`TPCT_IDX_MODE, 2'b00};
  wire hit_clkedge = paddr_in == {`TPCT_IDX_CLKEDGE, 2'b00};
  wire hit_div = paddr_in == {`TPCT_IDX_DIV, 2'b00};
  wire hit_count = paddr_in == {`TPCT_IDX_COUNT, 2'b00};
  wire hit_cap0 = paddr_in == {`TPCT_IDX_CAP0, 2'b00};
  wire hit_cap1 = paddr_in == {`TPCT_IDX_CAP1, 2'b00};
  wire hit_cap2 = paddr_in == {`TPCT_IDX_CAP2, 2'b00};
  wire hit_any = hit_mode || hit_clkedge || hit_div || hit_count ||
                 hit_cap0 || hit_cap1 || hit_cap2;
  wire access_done = psel_in && penable_in && pready_q && !pslverr_q;
  wire wr_en = access_done && pwrite_in;
  wire wr_mode = wr_en && hit_mode;
  wire wr_clkedge = wr_en && hit_clkedge;
  wire wr_div = wr_en && hit_div;
  wire [31:0] rd_data =
    hit_mode ? {24'h000000, mode_control_reg_q} :
    hit_clkedge ? {24'h000000, clock_edge_reg_q} :
    hit_div ? {24'h000000, capture_divider_reg_q} :
    hit_count ? {{(32-CNT_W){1'b0}}, free_running_counter_q} :
    hit_cap0 ? {{(32-CNT_W){1'b0}}, cap_q[0]} :
    hit_cap1 ? {{(32-CNT_W){1'b0}}, cap_q[1]} :
    hit_cap2 ? {{(32-CNT_W){1'b0}}, cap_q[2]} :
    32'h00000000;

  // APB response, one access cycle
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !hit_any;
      if (setup) begin
        prdata_q <= (!pwrite_in && hit_any) ? rd_data : 32'h00000000;
      end
    end
  end

  // Control registers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_control_reg_q <= `TPCT_RST_MODE;
      clock_edge_reg_q <= `TPCT_RST_CLKEDGE;
      capture_divider_reg_q <= `TPCT_RST_DIV;
    end else begin
      if (wr_mode) begin
        mode_control_reg_q <= pwdata_in[7:0] & `TPCT_MODE_MASK;
      end
      if (wr_clkedge) begin
        clock_edge_reg_q <= pwdata_in[7:0];
      end
      if (wr_div) begin
        capture_divider_reg_q <= pwdata_in[7:0] & `TPCT_DIV_MASK;
      end
    end
  end

  // Free-running counter; prescaler runs free so start lags a tick
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      free_running_counter_q <= CNT_W'(`TPCT_RST_COUNT);
    end else if (run_bit && tick) begin
      free_running_counter_q <= free_running_counter_q + CNT_W'(1);
    end
  end

  // Prescaler signal out
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      presc_out_q <= 1'b0;
      presc_oe_q <= 1'b0;
    end else begin
      presc_oe_q <= prescaler_out_enable;
      presc_out_q <= prescaler_out_enable && presc_sig;
    end
  end

  // Capture channels
  wire [NCH-1:0] pins = {capture_in_2_in, capture_in_1_in, capture_in_0_in};
  logic [NCH-1:0] edge_hit;
  logic [NCH-1:0] trig;
  logic [2:0] div_lim;

  always_comb begin
    unique case (tpct_pkg::tpct_div_sel_t'(div_sel))
      tpct_pkg::TPCT_CAPDIV_1: div_lim = `TPCT_LIM_DIV1;
      tpct_pkg::TPCT_CAPDIV_2: div_lim = `TPCT_LIM_DIV2;
      tpct_pkg::TPCT_CAPDIV_4: div_lim = `TPCT_LIM_DIV4;
      tpct_pkg::TPCT_CAPDIV_8: div_lim = `TPCT_LIM_DIV8;
    endcase
  end

  wire div_wrap = div_cnt_q == div_lim;
  assign trig[0] = edge_hit[0];
  assign trig[1] = edge_hit[1];
  assign trig[2] = edge_hit[2] && div_wrap;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_cnt_q <= 3'h0;
    end else if (!run_bit) begin
      div_cnt_q <= 3'h0;
    end else if (edge_hit[2]) begin
      div_cnt_q <= div_wrap ? 3'h0 : div_cnt_q + 3'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      tpct_capture_chan u_chan (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .pin_in(pins[g]),
        .tick_in(tick),
        .run_in(run_bit),
        .edge_sel_in(edge_sel[g]),
        .edge_out(edge_hit[g])
      );
      // Capture is never held off by a bus read
      always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          cap_q[g] <= '0;
          irq_q[g] <= 1'b0;
        end else begin
          irq_q[g] <= trig[g];
          if (trig[g]) begin
            cap_q[g] <= free_running_counter_q;
          end
        end
      end
    end
  endgenerate

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign capture_irq_0_out = irq_q[0];
  assign capture_irq_1_out = irq_q[1];
  assign capture_irq_2_out = irq_q[2];
  assign prescaler_out_out = presc_out_q;
  assign prescaler_oe_out = presc_oe_q;

  // Checks
  chk_count_step: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    run_bit && tick |=> free_running_counter_q ==
      $past(free_running_counter_q) + CNT_W'(1))
    else $error("counter did not step on tick");
  chk_count_stop: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    !run_bit |=> $stable(free_running_counter_q))
    else $error("counter moved while stopped");
  chk_tick_spacing: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    tick |=> !tick [*3])
    else $error("count ticks closer than four clocks");
  chk_tick_div4: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    tick ##3 clk_sel == 2'b00
      |=> tick)
    else $error("div4 tick period wrong");
  chk_presc_gate: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    !prescaler_out_enable |=> !prescaler_oe_out && !prescaler_out_out)
    else $error("prescaler output driven while disabled");
  chk_presc_on: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    prescaler_out_enable |=> prescaler_oe_out)
    else $error("prescaler output not enabled");
  chk_capture_value: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    trig[0] |=> cap_q[0] == $past(free_running_counter_q) && irq_q[0])
    else $error("capture 0 value or request wrong");
  chk_capture_two: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    trig[1] |=> cap_q[1] == $past(free_running_counter_q) && irq_q[1])
    else $error("capture 1 value or request wrong");
  chk_irq_pulse: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    irq_q[2] && !trig[2] |=> !irq_q[2])
    else $error("request longer than one cycle");
  chk_div_bypass: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    edge_hit[2] && div_sel == 2'b00 |=> irq_q[2])
    else $error("undivided capture 2 missed");
  chk_div_count: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    edge_hit[2] && div_cnt_q != div_lim |=> !irq_q[2])
    else $error("capture 2 fired before divider wrap");
  chk_read_capture: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    trig[0] && psel_in && !pwrite_in |=> irq_q[0])
    else $error("capture lost during read");
  chk_mode_write: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    wr_mode |=> mode_control_reg_q ==
      ($past(pwdata_in[7:0]) & `TPCT_MODE_MASK))
    else $error("mode write not taken");

  cov_irq0: cover property (@(posedge core_clk_in)
    disable iff (!resetn_in) irq_q[0]);
  cov_all_three: cover property (@(posedge core_clk_in)
    disable iff (!resetn_in) &irq_q);
  cov_div8: cover property (@(posedge core_clk_in)
    disable iff (!resetn_in) trig[2] && div_sel == 2'b11);
  cov_presc: cover property (@(posedge core_clk_in)
    disable iff (!resetn_in) prescaler_out_out);
endmodule

// ---- pkg/tpct_map.svh ----
// Register indices, field positions, reset values and timing counts
`ifndef TPCT_MAP_SVH
`define TPCT_MAP_SVH
`define TPCT_APB_AW 18
`define TPCT_IDX_MODE 16'hFF65
`define TPCT_IDX_CLKEDGE 16'hFF66
`define TPCT_IDX_DIV 16'hFF67
`define TPCT_IDX_COUNT 16'hFF60
`define TPCT_IDX_CAP0 16'hFF61
`define TPCT_IDX_CAP1 16'hFF62
`define TPCT_IDX_CAP2 16'hFF63
`define TPCT_MODE_RUN_BIT 2
`define TPCT_MODE_POE_BIT 0
`define TPCT_MODE_MASK 8'h05
`define TPCT_DIV_MASK 8'h03
`define TPCT_CLK_SEL_LSB 0
`define TPCT_EDGE0_LSB 2
`define TPCT_EDGE1_LSB 4
`define TPCT_EDGE2_LSB 6
`define TPCT_RST_MODE 8'h00
`define TPCT_RST_CLKEDGE 8'h00
`define TPCT_RST_DIV 8'h00
`define TPCT_RST_COUNT 16'h0000
`define TPCT_PRESC_W 7
`define TPCT_MASK_DIV4 7'h03
`define TPCT_MASK_DIV8 7'h07
`define TPCT_MASK_DIV32 7'h1F
`define TPCT_MASK_DIV128 7'h7F
`define TPCT_LIM_DIV1 3'h0
`define TPCT_LIM_DIV2 3'h1
`define TPCT_LIM_DIV4 3'h3
`define TPCT_LIM_DIV8 3'h7
`endif

// ---- pkg/tpct_pkg.sv ----
// Types for the pulse capture timer
package tpct_pkg;
  typedef enum logic [1:0] {
    TPCT_CLK_DIV4 = 2'b00,
    TPCT_CLK_DIV8 = 2'b01,
    TPCT_CLK_DIV32 = 2'b10,
    TPCT_CLK_DIV128 = 2'b11
  } tpct_clk_sel_t;
  typedef enum logic [1:0] {
    TPCT_EDGE_FALL = 2'b00,
    TPCT_EDGE_RISE = 2'b01,
    TPCT_EDGE_BAD = 2'b10,
    TPCT_EDGE_BOTH = 2'b11
  } tpct_edge_sel_t;
  typedef enum logic [1:0] {
    TPCT_CAPDIV_1 = 2'b00,
    TPCT_CAPDIV_2 = 2'b01,
    TPCT_CAPDIV_4 = 2'b10,
    TPCT_CAPDIV_8 = 2'b11
  } tpct_div_sel_t;
endpackage

// ---- hw/tpct_prescaler.sv ----
// Free-running prescaler producing the count tick
`timescale 1ns/1ps
`include "tpct_map.svh"
module tpct_prescaler (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [1:0] clk_sel_in,
  output logic tick_out,
  output logic presc_sig_out
);
  logic [`TPCT_PRESC_W-1:0] presc_q;
  logic [`TPCT_PRESC_W-1:0] mask;
  logic tick_q;
  logic sig_q;
  always_comb begin
    unique case (tpct_pkg::tpct_clk_sel_t'(clk_sel_in))
      tpct_pkg::TPCT_CLK_DIV4: mask = `TPCT_MASK_DIV4;
      tpct_pkg::TPCT_CLK_DIV8: mask = `TPCT_MASK_DIV8;
      tpct_pkg::TPCT_CLK_DIV32: mask = `TPCT_MASK_DIV32;
      tpct_pkg::TPCT_CLK_DIV128: mask = `TPCT_MASK_DIV128;
    endcase
  end
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      presc_q <= '0;
      tick_q <= 1'b0;
      sig_q <= 1'b0;
    end else begin
      presc_q <= presc_q + 7'h01;
      tick_q <= (presc_q & mask) == mask;
      sig_q <= presc_q[`TPCT_PRESC_W-1];
    end
  end
  assign tick_out = tick_q;
  assign presc_sig_out = sig_q;
endmodule

// ---- hw/tpct_capture_chan.sv ----
// One capture input: synchroniser, two-sample filter, edge select
`timescale 1ns/1ps
module tpct_capture_chan (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic pin_in,
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic [1:0] edge_sel_in,
  output logic edge_out
);
  logic sync1_q, sync2_q, smp_a_q, smp_b_q, level_q, edge_q;
  logic agree, change, valid;
  assign agree = smp_a_q == smp_b_q;
  assign change = agree && (smp_a_q != level_q);
  always_comb begin
    unique case (tpct_pkg::tpct_edge_sel_t'(edge_sel_in))
      tpct_pkg::TPCT_EDGE_FALL: valid = !smp_a_q;
      tpct_pkg::TPCT_EDGE_RISE: valid = smp_a_q;
      tpct_pkg::TPCT_EDGE_BAD: valid = 1'b0;
      tpct_pkg::TPCT_EDGE_BOTH: valid = 1'b1;
    endcase
  end
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      smp_a_q <= 1'b0;
      smp_b_q <= 1'b0;
      level_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      if (!run_in) begin
        smp_a_q <= 1'b0;
        smp_b_q <= 1'b0;
        level_q <= 1'b0;
      end else begin
        if (tick_in) begin
          smp_a_q <= sync2_q;
          smp_b_q <= smp_a_q;
        end
        if (change) begin
          level_q <= smp_a_q;
        end
      end
      edge_q <= run_in && change && valid;
    end
  end
  assign edge_out = edge_q;

  chk_two_samples: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) edge_out |-> $past(agree))
    else $error("edge without two equal samples");
  chk_bad_code: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) edge_sel_in == 2'b10 |=> !edge_out)
    else $error("edge taken on prohibited code");
  chk_stop_quiet: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in) !run_in |=> !edge_out)
    else $error("edge while stopped");
endmodule

// ---- verification/tpct_pulse_src.sv ----
// Pulse source model for the three capture input pins
`timescale 1ns/1ps
module tpct_pulse_src (
  input wire logic core_clk_in,
  output logic [2:0] pin_out
);
  initial pin_out = 3'h0;
  // Sets all three pins one cycle after the call
  task automatic set_pins(input logic [2:0] v);
    @(posedge core_clk_in);
    pin_out <= v;
  endtask
  // One-cycle noise spike, shorter than two count samples
  task automatic glitch(input int ch);
    @(posedge core_clk_in);
    pin_out[ch] <= ~pin_out[ch];
    @(posedge core_clk_in);
    pin_out[ch] <= ~pin_out[ch];
  endtask
endmodule

// ---- verification/testbench.sv ----
// Self-checking testbench for the pulse capture timer
`timescale 1ns/1ps
`include "tpct_map.svh"
module testbench;
  logic core_clk, resetn, psel, penable, pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, p_out, p_oe;
  logic [2:0] pins, irq, irq_prev;
  logic [31:0] c0, c1, p0, p1, p2, r;
  logic e, f;
  int fail_count, checks_done, cyc, t1, tg;
  int cnt[3], base[3];
  logic [1:0] codes[3] = '{2'b00, 2'b01, 2'b11};
  int divs[4] = '{4, 8, 32, 128};

  tpct_pulse_src i_src (.core_clk_in(core_clk), .pin_out(pins));
  tpct_top i_dut (
    .core_clk_in(core_clk), .resetn_in(resetn), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .capture_in_0_in(pins[0]),
    .capture_in_1_in(pins[1]), .capture_in_2_in(pins[2]),
    .capture_irq_0_out(irq[0]), .capture_irq_1_out(irq[1]),
    .capture_irq_2_out(irq[2]), .prescaler_out_out(p_out),
    .prescaler_oe_out(p_oe));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    irq_prev <= irq;
    for (int i = 0; i < 3; i++) cnt[i] <= cnt[i] + irq[i];
    if ((irq & irq_prev) != 3'h0) check(irq & irq_prev, 32'h0);
  end

  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    t1 = cyc;
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check(32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    logic [31:0] d;
    logic er;
    apb(1'b1, idx, {24'h000000, v}, d, er);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] v);
    logic er;
    apb(1'b0, idx, 32'h00000000, v, er);
  endtask

  task automatic rd_burst(input logic [15:0] idx, input int n);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= 1'b0;
    paddr <= {idx, 2'b00};
    repeat (n) begin
      penable <= 1'b0;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic snap();
    for (int i = 0; i < 3; i++) base[i] = cnt[i];
  endtask

  task automatic exp_irq(input int n0, input int n1, input int n2);
    repeat (100) @(posedge core_clk);
    check(cnt[0] - base[0], n0);
    check(cnt[1] - base[1], n1);
    check(cnt[2] - base[2], n2);
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    test_done();
  end

  initial begin
    resetn = 1'b0;
    {psel, penable} = 2'b00;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`TPCT_IDX_MODE, r); check(r, 32'h0);
    rd(`TPCT_IDX_CLKEDGE, r); check(r, 32'h0);
    rd(`TPCT_IDX_DIV, r); check(r, 32'h0);
    rd(`TPCT_IDX_COUNT, r); check(r, 32'h0);
    wr(`TPCT_IDX_DIV, 8'h02);
    rd(`TPCT_IDX_DIV, r); check(r, 32'h2);
    wr(`TPCT_IDX_DIV, 8'h00);
    wr(`TPCT_IDX_CLKEDGE, 8'hD7);
    rd(`TPCT_IDX_CLKEDGE, r); check(r, 32'hD7);
    apb(1'b0, 16'hFF70, 32'h0, r, e); check(e, 1'b1);
    $display("registers done");
    wr(`TPCT_IDX_MODE, 8'h01);
    tg = 0;
    repeat (300) begin
      @(posedge core_clk);
      f = p_out;
      @(posedge core_clk);
      if (p_out !== f) tg++;
    end
    check(p_oe, 1'b1);
    check(tg >= 3, 1'b1);
    wr(`TPCT_IDX_MODE, 8'h00);
    repeat (3) @(posedge core_clk);
    check({p_oe, p_out}, 2'b00);
    $display("prescaler output done");
    for (int k = 0; k < 4; k++) begin
      wr(`TPCT_IDX_MODE, 8'h00);
      wr(`TPCT_IDX_CLKEDGE, k[7:0]);
      wr(`TPCT_IDX_MODE, 8'h04);
      rd(`TPCT_IDX_COUNT, c0);
      tg = t1;
      repeat (64 * divs[k]) @(posedge core_clk);
      rd(`TPCT_IDX_COUNT, c1);
      tg = t1 - tg;
      r = c1 - c0;
      e = (r == tg / divs[k]) || (r == (tg + divs[k] - 1) / divs[k]);
      check(e, 1'b1);
    end
    $display("count clock done");
    for (int k = 0; k < 3; k++) begin
      wr(`TPCT_IDX_MODE, 8'h00);
      wr(`TPCT_IDX_CLKEDGE, {codes[k], codes[k], codes[k], 2'b00});
      wr(`TPCT_IDX_MODE, 8'h04);
      snap();
      rd(`TPCT_IDX_COUNT, c0);
      i_src.set_pins(3'b111);
      e = codes[k][0];
      exp_irq(e, e, e);
      rd(`TPCT_IDX_COUNT, c1);
      if (e) begin
        rd(`TPCT_IDX_CAP0, p0);
        rd(`TPCT_IDX_CAP1, p1);
        rd(`TPCT_IDX_CAP2, p2);
        check(p0 >= c0 && p0 <= c1, 1'b1);
        check(p1, p0);
        check(p2, p0);
      end
      snap();
      i_src.set_pins(3'b000);
      f = (codes[k] != 2'b01);
      exp_irq(f, f, f);
    end
    $display("edge select done");
    wr(`TPCT_IDX_MODE, 8'h00);
    wr(`TPCT_IDX_CLKEDGE, 8'hD4);
    wr(`TPCT_IDX_MODE, 8'h04);
    snap();
    i_src.glitch(0);
    exp_irq(0, 0, 0);
    wr(`TPCT_IDX_MODE, 8'h00);
    i_src.set_pins(3'b111);
    repeat (20) @(posedge core_clk);
    snap();
    wr(`TPCT_IDX_MODE, 8'h04);
    rd_burst(`TPCT_IDX_CAP0, 12);
    exp_irq(1, 1, 1);
    wr(`TPCT_IDX_MODE, 8'h00);
    i_src.set_pins(3'b000);
    repeat (20) @(posedge core_clk);
    snap();
    wr(`TPCT_IDX_MODE, 8'h04);
    exp_irq(0, 0, 0);
    $display("filter and start done");
    for (int d = 0; d < 4; d++) begin
      wr(`TPCT_IDX_MODE, 8'h00);
      wr(`TPCT_IDX_DIV, d[7:0]);
      wr(`TPCT_IDX_CLKEDGE, 8'h40);
      wr(`TPCT_IDX_MODE, 8'h04);
      snap();
      repeat (8) begin
        i_src.set_pins(3'b100);
        repeat (20) @(posedge core_clk);
        i_src.set_pins(3'b000);
        repeat (20) @(posedge core_clk);
      end
      exp_irq(0, 0, 8 >> d);
    end
    $display("divider done");
    test_done();
  end
endmodule
